// File: include/npess_pkg.sv
// Constants, command codes, status bits and timing for the NAND sequencer host.
// Assumes a single 125 MHz clock; device pins are sampled synchronously.
// What this block does
// [R1] Cached pages end with 15h, not 10h
// [R2] Device briefly busy moving cache to data
// [R3] Cache only consecutive pages, one block, 2112
// [R4] Status bit 6 shows cache ready
// [R5] Cache ready reports previous page on bit 1
// [R6] Device waits pending program before cache move
// [R7] Status bit 5 shows true internal ready
// [R8] Pin-only hosts end sequence with 10h
// [R9] Final page waits for previous cached cycle
// [R10] 35h loads whole source page into buffer
// [R11] Copy-back: 85h, destination, reloads, then 10h
// [R12] Copy-back result on bit 0, status mode
// [R13] Erase: 60h, three row cycles, D0h
// [R14] Erase starts on D0h, result bit 0
// [R15] Status read allowed right after D0h
// [R16] Status driven on later falling strobe edge
// [R17] Status output tracks changes live
// [R18] After status, issue 00h before reading data
// [R19] Status bit meanings: fail, ready, protect
// [R20] Shared busy line: poll each device
// [R21] Only status and reset accepted while busy
package npess_pkg;

  // Operations offered at the user port
  typedef enum logic [2:0] {
    OP_PROG      = 3'h0,
    OP_CACHE     = 3'h1,
    OP_CB_READ   = 3'h2,
    OP_CB_PROG   = 3'h3,
    OP_CB_RELOAD = 3'h4,
    OP_ERASE     = 3'h5,
    OP_STATUS    = 3'h6
  } npess_op_e;

  // Kinds of bus cycle on the byte port
  typedef enum logic [1:0] {
    K_CMD  = 2'h0,
    K_ADDR = 2'h1,
    K_WR   = 2'h2,
    K_RD   = 2'h3
  } npess_kind_e;

  // Command codes
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_CACHE = 8'h15;
  localparam logic [7:0] CMD_CB_READ = 8'h35;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_DATA_IN = 8'h80;
  localparam logic [7:0] CMD_CB_DATA = 8'h85;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;

  // Status byte fields
  localparam int ST_FAIL = 0;
  localparam int ST_PREV_FAIL = 1;
  localparam int ST_TRUE_RDY = 5;
  localparam int ST_RDY = 6;
  localparam int ST_NOT_WP = 7;

  // Page geometry and address layout
  localparam int PAGE_BYTES = 2112;
  localparam int LEN_W = 12;
  localparam int ADDR_W = 40;
  localparam int ROW_LSB = 16;
  localparam int ROW_W = 24;
  localparam int PAGE_BITS = 6;
  localparam int NADDR_FULL = 5;
  localparam int NADDR_COL = 2;
  localparam int NADDR_ROW = 3;

  // Clock rate and bus timing, times in ns
  localparam int CLK_MHZ = 125;
  localparam int T_SETUP_NS = 12;
  localparam int T_WP_NS = 12;
  localparam int T_WH_NS = 10;
  localparam int T_REA_NS = 20;
  localparam int T_REH_NS = 10;
  localparam int T_WB_NS = 100;

  // Least time in ns to whole cycles, rounded up, never below one
  function automatic int npess_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : npess_cyc

  localparam int SETUP_CYC = npess_cyc(T_SETUP_NS);
  localparam int WP_CYC = npess_cyc(T_WP_NS);
  localparam int WH_CYC = npess_cyc(T_WH_NS);
  localparam int REA_CYC = npess_cyc(T_REA_NS);
  localparam int REH_CYC = npess_cyc(T_REH_NS);
  localparam int WB_CYC = npess_cyc(T_WB_NS);

endpackage : npess_pkg

// File: logic/npess_cycle.sv
// One command, address, data-in or data-out cycle on the NAND byte port.
// Assumes the caller holds start_i for one cycle only while the unit is idle.
`timescale 1ns/100ps
module npess_cycle (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Request from the sequencer
  input wire logic start_i,
  input wire npess_pkg::npess_kind_e kind_i,
  input wire logic [7:0] byte_i,
  output logic done_o,
  output logic [7:0] rd_byte_o,
  // Device strobes and byte port
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic re_n_o,
  output logic [7:0] io_o,
  output logic io_oe_o,
  input wire logic [7:0] io_i
);
  import npess_pkg::*;

  // Cycle phases, one-hot
  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_SET = 4'h2,
    C_LOW = 4'h4,
    C_HIGH = 4'h8
  } npess_cph_e;

  // Whole state of the unit
  typedef struct packed {
    npess_cph_e ph;       // Phase
    logic [7:0] cnt;      // Cycles left in phase
    logic rd;             // Current cycle is a read
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] io;
    logic oe;
    logic [7:0] rdat;     // Captured read byte
    logic done;           // One-cycle completion pulse
  } npess_cyc_s;

  npess_cyc_s st;
  npess_cyc_s next_st;

  // Phase sequencing; strobes only change at phase boundaries so no glitches
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.ph)
      C_IDLE: begin
        if (start_i) begin
          next_st.rd = (kind_i == K_RD);
          next_st.cle = (kind_i == K_CMD);
          next_st.ale = (kind_i == K_ADDR);
          next_st.io = byte_i;
          next_st.oe = (kind_i != K_RD);
          next_st.cnt = 8'(SETUP_CYC - 1);
          next_st.ph = C_SET;
        end
      end
      C_SET: begin
        if (st.cnt == 8'h00) begin
          // Strobe falls after latch lines and data settle
          if (st.rd) begin
            next_st.re_n = 1'b0;
            next_st.cnt = 8'(REA_CYC - 1);
          end else begin
            next_st.we_n = 1'b0;
            next_st.cnt = 8'(WP_CYC - 1);
          end
          next_st.ph = C_LOW;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      C_LOW: begin
        if (st.cnt == 8'h00) begin
          if (st.rd) begin
            // Byte is valid once access time has passed after the strobe fell
            next_st.rdat = io_i; // R16
            next_st.re_n = 1'b1;
            next_st.cnt = 8'(REH_CYC - 1);
          end else begin
            // Rising edge latches the byte into the device
            next_st.we_n = 1'b1; // R14
            next_st.cnt = 8'(WH_CYC - 1);
          end
          next_st.ph = C_HIGH;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      C_HIGH: begin
        if (st.cnt == 8'h00) begin
          // Data and latch lines held through the high time for hold margin
          next_st.cle = 1'b0;
          next_st.ale = 1'b0;
          next_st.oe = 1'b0;
          next_st.done = 1'b1;
          next_st.ph = C_IDLE;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      default: begin
        next_st.ph = C_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '{ph: C_IDLE, cnt: 8'h00, rd: 1'b0, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
              re_n: 1'b1, io: 8'h00, oe: 1'b0, rdat: 8'h00, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign done_o = st.done;
  assign rd_byte_o = st.rdat;
  assign cle_o = st.cle;
  assign ale_o = st.ale;
  assign we_n_o = st.we_n;
  assign re_n_o = st.re_n;
  assign io_o = st.io;
  assign io_oe_o = st.oe;

endmodule : npess_cycle

// File: logic/npess_host.sv
// Host sequencer for NAND program, cache program, copy-back, erase and status.
// Assumes one device on the pins; the ready/busy pin is already synchronous.
`timescale 1ns/100ps
module npess_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Operation request
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire npess_pkg::npess_op_e cmd_op_i,
  input wire logic [npess_pkg::ADDR_W-1:0] cmd_addr_i,
  input wire logic [npess_pkg::LEN_W-1:0] cmd_len_i,
  input wire logic cmd_last_i,
  input wire logic poll_mode_i,
  // Write data stream
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  // Read data stream
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  // Completion
  output logic done_o,
  output logic fail_o,
  output logic seq_err_o,
  output logic [7:0] status_o,
  // Device pins
  output logic ce_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic re_n_o,
  output logic [7:0] io_o,
  output logic io_oe_o,
  input wire logic [7:0] io_i,
  input wire logic rb_n_i
);
  import npess_pkg::*;

  // Sequencer states, one-hot
  typedef enum logic [11:0] {
    S_IDLE = 12'h001,
    S_CMD1 = 12'h002,
    S_ADDR = 12'h004,
    S_DATA = 12'h008,
    S_CONF = 12'h010,
    S_TWB = 12'h020,
    S_WAIT = 12'h040,
    S_POLLC = 12'h080,
    S_POLLR = 12'h100,
    S_RDMODE = 12'h200,
    S_RDDATA = 12'h400,
    S_DONE = 12'h800
  } npess_st_e;

  // Whole state of the sequencer
  typedef struct packed {
    npess_st_e fsm;
    npess_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] len;
    logic last;
    logic poll;
    logic [LEN_W-1:0] cnt;     // Address, byte or wait counter
    logic pend;                // Bus cycle in flight
    logic pre;                 // Polling before a new command
    logic polled;              // Device left in status mode
    logic arr_busy;            // Array may still be programming
    logic in_seq;              // Inside a cached page sequence
    logic [ROW_W-1:0] last_row;
    logic ce_n;
    logic [7:0] status;
    logic fail;
    logic err;
    logic done;
    logic rd_valid;
    logic [7:0] rd_data;
  } npess_host_s;

  npess_host_s st;
  npess_host_s next_st;

  // Bus cycle unit handshake
  logic cyc_go;
  npess_kind_e cyc_kind;
  logic [7:0] cyc_byte;
  logic cyc_done;
  logic [7:0] cyc_rd;
  logic fin;
  logic [ROW_W-1:0] new_row;
  logic seq_ok;

  // Opening command of each operation
  function automatic logic [7:0] first_cmd(input npess_op_e op);
    case (op)
      OP_PROG, OP_CACHE: return CMD_DATA_IN;
      OP_CB_PROG, OP_CB_RELOAD: return CMD_CB_DATA; // R11
      OP_CB_READ: return CMD_READ;
      OP_ERASE: return CMD_ERASE; // R13
      default: return CMD_STATUS;
    endcase
  endfunction : first_cmd

  // Number of address cycles of each operation
  function automatic logic [LEN_W-1:0] addr_cycles(input npess_op_e op);
    case (op)
      OP_CB_RELOAD: return LEN_W'(NADDR_COL);
      OP_ERASE: return LEN_W'(NADDR_ROW); // R13
      default: return LEN_W'(NADDR_FULL);
    endcase
  endfunction : addr_cycles

  // Closing command; cached pages use 15h except the final page
  function automatic logic [7:0] conf_cmd(input npess_op_e op, input logic last);
    case (op)
      OP_CACHE: return last ? CMD_CONFIRM : CMD_CACHE; // R1 R8
      OP_ERASE: return CMD_ERASE_GO; // R13
      OP_CB_READ: return CMD_CB_READ; // R10
      default: return CMD_CONFIRM; // R11
    endcase
  endfunction : conf_cmd

  // Address byte for a given cycle; erase sends row bytes only
  function automatic logic [7:0] addr_byte(input logic [ADDR_W-1:0] a, input npess_op_e op,
                                           input logic [LEN_W-1:0] idx);
    logic [2:0] i;
    i = (op == OP_ERASE) ? 3'(idx + LEN_W'(2)) : idx[2:0];
    case (i)
      3'h0: return a[7:0];
      3'h1: return a[15:8];
      3'h2: return a[23:16];
      3'h3: return a[31:24];
      default: return a[39:32];
    endcase
  endfunction : addr_byte

  // A cached sequence must step one page at a time inside one block
  assign new_row = cmd_addr_i[ROW_LSB +: ROW_W];
  assign seq_ok = !st.in_seq ||
                  ((new_row == st.last_row + ROW_W'(1)) &&
                   (new_row[ROW_W-1:PAGE_BITS] == st.last_row[ROW_W-1:PAGE_BITS])); // R3

  assign fin = st.pend && cyc_done;

  // Sequencer
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.rd_valid = 1'b0;
    cyc_go = 1'b0;
    cyc_kind = K_CMD;
    cyc_byte = 8'h00;
    if (fin) begin
      next_st.pend = 1'b0;
    end
    case (st.fsm)
      S_IDLE: begin
        if (cmd_valid_i) begin
          next_st.op = cmd_op_i;
          next_st.addr = cmd_addr_i;
          next_st.len = cmd_len_i;
          next_st.last = cmd_last_i;
          next_st.poll = poll_mode_i;
          next_st.cnt = '0;
          next_st.err = 1'b0;
          next_st.ce_n = 1'b0;
          if (((cmd_op_i == OP_CACHE || cmd_op_i == OP_PROG) && !seq_ok) ||
              (cmd_len_i > LEN_W'(PAGE_BYTES))) begin
            next_st.err = 1'b1; // R3
            next_st.fsm = S_DONE;
          end else if (st.arr_busy && cmd_op_i != OP_CACHE && cmd_op_i != OP_PROG &&
                       cmd_op_i != OP_STATUS) begin
            // Other commands wait for a status poll to show the array idle, then are sent
            next_st.pre = 1'b1; // R21
            next_st.fsm = S_POLLC;
          end else begin
            next_st.fsm = S_CMD1;
          end
        end
      end
      S_CMD1: begin
        cyc_byte = first_cmd(st.op);
        cyc_go = !st.pend;
        if (fin) begin
          next_st.polled = 1'b0;
          if (st.op == OP_STATUS) begin
            next_st.polled = 1'b1;
            next_st.fsm = S_POLLR;
          end else begin
            next_st.fsm = S_ADDR;
          end
        end
      end
      S_ADDR: begin
        cyc_kind = K_ADDR;
        cyc_byte = addr_byte(st.addr, st.op, st.cnt);
        cyc_go = !st.pend;
        if (fin) begin
          next_st.cnt = st.cnt + LEN_W'(1);
          if (st.cnt == addr_cycles(st.op) - LEN_W'(1)) begin
            next_st.cnt = '0;
            if (st.op == OP_CB_READ || st.op == OP_ERASE) begin
              next_st.fsm = S_CONF;
            end else if (st.len != '0) begin
              // Copy-back data reload is optional
              next_st.fsm = S_DATA; // R11
            end else begin
              // A cached page always closes, with 15h unless it is the last
              next_st.fsm = (st.last || st.op == OP_CACHE) ? S_CONF : S_DONE; // R1
            end
          end
        end
      end
      S_DATA: begin
        cyc_kind = K_WR;
        cyc_byte = wr_data_i;
        cyc_go = !st.pend && wr_valid_i;
        if (fin) begin
          next_st.cnt = st.cnt + LEN_W'(1);
          if (st.cnt == st.len - LEN_W'(1)) begin
            next_st.cnt = '0;
            next_st.fsm = (st.last || st.op == OP_CACHE) ? S_CONF : S_DONE; // R1
          end
        end
      end
      S_CONF: begin
        cyc_byte = conf_cmd(st.op, st.last);
        cyc_go = !st.pend;
        if (fin) begin
          next_st.cnt = '0;
          next_st.fsm = S_TWB;
        end
      end
      S_TWB: begin
        // Busy only shows after the write-to-busy delay
        next_st.cnt = st.cnt + LEN_W'(1);
        if (st.cnt == LEN_W'(WB_CYC - 1)) begin
          next_st.fsm = st.poll ? S_POLLC : S_WAIT; // R15 R20
        end
      end
      S_WAIT: begin
        // Pin high covers cache transfer and any pending array cycle
        if (rb_n_i) begin // R2 R6 R9
          next_st.cnt = '0;
          next_st.fsm = (st.op == OP_CB_READ && st.len != '0) ? S_RDDATA : S_DONE;
        end
      end
      S_POLLC: begin
        cyc_byte = CMD_STATUS; // R4
        cyc_go = !st.pend;
        if (fin) begin
          next_st.polled = 1'b1;
          next_st.fsm = S_POLLR;
        end
      end
      S_POLLR: begin
        // Re-reading each pass is harmless; the device updates it live anyway
        cyc_kind = K_RD;
        cyc_go = !st.pend; // R17
        if (fin) begin
          next_st.status = cyc_rd;
          if (st.pre) begin
            if (cyc_rd[ST_RDY] && cyc_rd[ST_TRUE_RDY]) begin // R7 R21
              next_st.pre = 1'b0;
              next_st.arr_busy = 1'b0;
              next_st.in_seq = 1'b0;
              next_st.fsm = S_CMD1;
            end
          end else if (st.op == OP_STATUS) begin
            next_st.fsm = S_DONE;
          end else if (st.op == OP_CACHE && !st.last) begin
            if (cyc_rd[ST_RDY]) begin // R4
              next_st.fsm = S_DONE;
            end
          end else if (cyc_rd[ST_RDY] && cyc_rd[ST_TRUE_RDY]) begin // R7 R9
            next_st.cnt = '0;
            next_st.fsm = (st.op == OP_CB_READ && st.len != '0) ? S_RDMODE : S_DONE;
          end
        end
      end
      S_RDMODE: begin
        // Device sits in status mode; read command restores data output
        cyc_byte = CMD_READ; // R18
        cyc_go = !st.pend;
        if (fin) begin
          next_st.polled = 1'b0;
          next_st.fsm = S_RDDATA;
        end
      end
      S_RDDATA: begin
        // No back-pressure: the user side must take every byte
        cyc_kind = K_RD;
        cyc_go = !st.pend; // R10
        if (fin) begin
          next_st.rd_data = cyc_rd;
          next_st.rd_valid = 1'b1;
          next_st.cnt = st.cnt + LEN_W'(1);
          if (st.cnt == st.len - LEN_W'(1)) begin
            next_st.fsm = S_DONE;
          end
        end
      end
      S_DONE: begin
        next_st.done = 1'b1;
        next_st.ce_n = 1'b1;
        next_st.fsm = S_IDLE;
        // Cached page other than the last reports the previous page on bit 1, others on bit 0
        if (st.op == OP_CACHE && !st.last) begin
          next_st.fail = st.polled && st.status[ST_PREV_FAIL]; // R5 R19
        end else begin
          next_st.fail = st.polled && st.status[ST_FAIL]; // R12 R14 R19
        end
        if (!st.err && (st.op == OP_CACHE || st.op == OP_PROG)) begin
          next_st.last_row = st.addr[ROW_LSB +: ROW_W];
          next_st.in_seq = (st.op == OP_CACHE) && !st.last; // R3
          next_st.arr_busy = (st.op == OP_CACHE) && !st.last; // R21
        end
        if (st.err) begin
          next_st.fail = 1'b1;
        end
      end
      default: begin
        next_st.fsm = S_IDLE;
      end
    endcase
    if (cyc_go) begin
      next_st.pend = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '{fsm: S_IDLE, op: OP_STATUS, addr: '0, len: '0, last: 1'b0, poll: 1'b0,
              cnt: '0, pend: 1'b0, pre: 1'b0, polled: 1'b0, arr_busy: 1'b0,
              in_seq: 1'b0, last_row: '0, ce_n: 1'b1, status: 8'h00, fail: 1'b0,
              err: 1'b0, done: 1'b0, rd_valid: 1'b0, rd_data: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  // Byte-port cycle engine
  npess_cycle u_cycle (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(cyc_go),
    .kind_i(cyc_kind),
    .byte_i(cyc_byte),
    .done_o(cyc_done),
    .rd_byte_o(cyc_rd),
    .cle_o(cle_o),
    .ale_o(ale_o),
    .we_n_o(we_n_o),
    .re_n_o(re_n_o),
    .io_o(io_o),
    .io_oe_o(io_oe_o),
    .io_i(io_i)
  );

  // User-side outputs
  assign cmd_ready_o = (st.fsm == S_IDLE);
  assign wr_ready_o = (st.fsm == S_DATA) && !st.pend;
  assign rd_valid_o = st.rd_valid;
  assign rd_data_o = st.rd_data;
  assign done_o = st.done;
  assign fail_o = st.fail;
  assign seq_err_o = st.err;
  assign status_o = st.status;
  assign ce_n_o = st.ce_n;

endmodule : npess_host

// File: verification/npess_dev_model.sv
// Behavioural NAND device answering the host sequencer's pins.
// Assumes pins are sampled on the host clock; times are in clock cycles.
`timescale 1ns/100ps
module npess_dev_model #(
  parameter int PROG_CYC = 40,
  parameter int CBSY_CYC = 6
) (
  // Clock, reset and fault order
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic fail_i,
  // Device pins
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic rb_n_o
);
  import npess_pkg::*;
  int rdy_cnt; // Cycles until the cache is free
  int arr_cnt; // Cycles until the array is idle
  logic we_q, re_q, st_mode, fail, pfail;
  logic [7:0] col, last, stat;
  // Status byte built live from the counters
  assign stat = {1'b1, rdy_cnt == 0, arr_cnt == 0, 3'h0, pfail, fail};
  assign rb_n_o = (rdy_cnt == 0);
  // Released bus shows the inverse of the last byte, so stale data never matches
  assign io_o = (!ce_n_i && !re_n_i) ? (st_mode ? stat : col) : ~last;
  // Counters every clock, read pointer on the rising read strobe, command decode on the rising write strobe
  always @(posedge clk_i) begin
    we_q <= we_n_i;
    re_q <= re_n_i;
    if (rdy_cnt > 0) rdy_cnt <= rdy_cnt - 1;
    if (arr_cnt > 0) arr_cnt <= arr_cnt - 1;
    if (!re_n_i) last <= io_o;
    if (re_n_i && !re_q && !st_mode) col <= col + 8'h01;
    if (srst_i) begin
      rdy_cnt <= 0;
      arr_cnt <= 0;
      st_mode <= 1'b0;
      fail <= 1'b0;
      pfail <= 1'b0;
      col <= 8'h00;
      last <= 8'h00;
    end else if (we_n_i && !we_q && cle_i && !ce_n_i) begin
      if (io_i == CMD_STATUS) begin
        st_mode <= 1'b1;
      end else if (rdy_cnt == 0) begin
        st_mode <= 1'b0;
        case (io_i)
          CMD_READ: col <= 8'h00;
          CMD_CB_READ: begin
            col <= 8'h00;
            rdy_cnt <= CBSY_CYC;
          end
          CMD_CACHE: begin
            rdy_cnt <= arr_cnt + CBSY_CYC;
            arr_cnt <= arr_cnt + PROG_CYC;
            pfail <= fail;
            fail <= fail_i;
          end
          CMD_CONFIRM, CMD_ERASE_GO: begin
            rdy_cnt <= arr_cnt + PROG_CYC;
            arr_cnt <= arr_cnt + PROG_CYC;
            fail <= fail_i;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : npess_dev_model

// File: verification/npess_host_chk.sv
// Pin and handshake checker for the NAND host sequencer.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module npess_host_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // User side
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire npess_pkg::npess_op_e cmd_op_i,
  input wire logic [npess_pkg::LEN_W-1:0] cmd_len_i,
  input wire logic done_o,
  input wire logic fail_o,
  input wire logic seq_err_o,
  // Device pins
  input wire logic cle_o,
  input wire logic ale_o,
  input wire logic we_n_o,
  input wire logic re_n_o,
  input wire logic [7:0] io_o,
  input wire logic io_oe_o,
  input wire logic rb_n_i
);
  import npess_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_busy_cmd: assert property ($rose(we_n_o) && cle_o && !rb_n_i |-> io_o == CMD_STATUS)
    else $error("command other than status sent while busy");
  chk_read_window: assert property ($fell(re_n_o) |-> (!re_n_o)[*3] ##1 re_n_o)
    else $error("read strobe low time wrong");
  chk_read_release: assert property (!re_n_o |-> !io_oe_o && we_n_o)
    else $error("host drives the bus during a read");
  chk_write_hold: assert property ($fell(we_n_o) |=> !we_n_o && $stable(io_o) && $stable(cle_o))
    else $error("byte moved under the write strobe");
  chk_latch_excl: assert property (!(cle_o && ale_o))
    else $error("command and address latch both high");
  chk_err_quiet: assert property (cmd_valid_i && cmd_ready_o && cmd_op_i == OP_PROG
      && cmd_len_i > 12'h840 |=> we_n_o throughout (##[0:3] (done_o && seq_err_o)))
    else $error("oversize page not refused quietly");
  chk_err_fail: assert property (done_o && seq_err_o |-> fail_o)
    else $error("refused operation without failure flag");
  chk_take_busy: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o && !done_o)
    else $error("taken request left the port ready");
  cov_err: cover property (done_o && seq_err_o);
  cov_cache: cover property ($rose(we_n_o) && cle_o && io_o == CMD_CACHE);
  cov_busy_poll: cover property ($rose(we_n_o) && cle_o && !rb_n_i);
endmodule : npess_host_chk
bind npess_host npess_host_chk u_chk (.clk_i, .srst_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i,
  .cmd_len_i, .done_o, .fail_o, .seq_err_o, .cle_o, .ale_o, .we_n_o, .re_n_o, .io_o, .io_oe_o,
  .rb_n_i);

// File: verification/npess_host_test.sv
// Self-checking bench: host sequencer against the behavioural device.
// Assumes a 125 MHz clock and the design's synchronous active-high reset.
`timescale 1ns/100ps
`define CHK(nm, e, a) \
  begin n_compared++; if ((a) !== (e)) begin \
  $display("wrong value %s expected %h seen %h", nm, e, a); bad_count++; end end
module npess_host_test;
  import npess_pkg::*;
  logic clk_i = 1'b0, srst_i = 1'b1, cmd_valid_i = 1'b0, cmd_last_i = 1'b0;
  logic poll_mode_i = 1'b0, wr_valid_i = 1'b1, dev_fail = 1'b0;
  npess_op_e cmd_op_i = OP_STATUS;
  logic [ADDR_W-1:0] cmd_addr_i = 40'h0;
  logic [LEN_W-1:0] cmd_len_i = 12'h0;
  logic [7:0] wr_data_i = 8'h00, rd_first, rd_data_o, status_o, io_o, io_i, dev_io;
  logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, fail_o, seq_err_o;
  logic ce_n_o, cle_o, ale_o, we_n_o, re_n_o, io_oe_o, rb_n_i;
  int bad_count = 0, n_compared = 0, n_wr, n_rd;
  // Wire level of the shared byte port
  assign io_i = io_oe_o ? io_o : dev_io;
  npess_host dut (.clk_i, .srst_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .cmd_addr_i,
    .cmd_len_i, .cmd_last_i, .poll_mode_i, .wr_valid_i, .wr_data_i, .wr_ready_o, .rd_valid_o,
    .rd_data_o, .done_o, .fail_o, .seq_err_o, .status_o, .ce_n_o, .cle_o, .ale_o, .we_n_o,
    .re_n_o, .io_o, .io_oe_o, .io_i, .rb_n_i);
  // Long array time so a cached page meets a program still running
  npess_dev_model #(.PROG_CYC(300)) dev (.clk_i, .srst_i, .fail_i(dev_fail), .ce_n_i(ce_n_o),
    .cle_i(cle_o), .we_n_i(we_n_o), .re_n_i(re_n_o), .io_i(io_i), .io_o(dev_io), .rb_n_o(rb_n_i));
  always #4 clk_i = ~clk_i;
  // Byte streams: count bytes taken and keep the first byte read
  always @(posedge clk_i) begin
    if (wr_valid_i && wr_ready_o) begin
      wr_data_i <= wr_data_i + 8'h01;
      n_wr++;
    end
    if (rd_valid_o) begin
      if (n_rd == 0) rd_first = rd_data_o;
      n_rd++;
    end
  end
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // One operation: offer it, drop the request once taken, wait for done
  task automatic run(input npess_op_e op, input int row, input int len, input logic last,
      input logic poll);
    int k;
    n_wr = 0;
    n_rd = 0;
    k = 0;
    cmd_op_i <= op;
    cmd_addr_i <= {row[23:0], 16'h0000};
    cmd_len_i <= len[LEN_W-1:0];
    cmd_last_i <= last;
    poll_mode_i <= poll;
    cmd_valid_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (cmd_ready_o === 1'b1) cmd_valid_i <= 1'b0;
      k++;
    end while (done_o !== 1'b1 && k < 20000);
    if (k >= 20000) begin
      bad_count++;
      wrap_up();
    end
  endtask : run
  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask : fin
  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    // Idle status: ready, not protected, no failure
    run(OP_STATUS, 0, 0, 1'b0, 1'b1);
    `CHK("status", 8'hE0, status_o)
    fin("status");
    run(OP_PROG, 'h80, 4, 1'b1, 1'b1);
    `CHK("bytes", 4, n_wr)
    `CHK("prog fail", 1'b0, fail_o)
    fin("program");
    // Cached pages: each but the final page reports the page before it
    dev_fail <= 1'b1;
    run(OP_CACHE, 'h40, 3, 1'b0, 1'b1);
    `CHK("cache 0", 1'b0, fail_o)
    dev_fail <= 1'b0;
    run(OP_CACHE, 'h41, 3, 1'b0, 1'b1);
    `CHK("cache 1", 1'b1, fail_o)
    run(OP_PROG, 'h42, 2, 1'b1, 1'b1);
    `CHK("last page", 1'b0, fail_o)
    `CHK("true ready", 1'b1, status_o[5])
    fin("cache");
    dev_fail <= 1'b1;
    run(OP_ERASE, 'hC0, 0, 1'b1, 1'b1);
    `CHK("erase fail", 1'b1, fail_o)
    run(OP_STATUS, 0, 0, 1'b0, 1'b1);
    `CHK("held status", 1'b1, status_o[0])
    fin("erase");
    // Copy-back: read source after leaving status mode, reload, confirm
    run(OP_CB_READ, 'h80, 3, 1'b0, 1'b1);
    `CHK("cb reads", 3, n_rd)
    `CHK("cb first", 8'h00, rd_first)
    run(OP_CB_PROG, 'h90, 2, 1'b0, 1'b1);
    run(OP_CB_RELOAD, 'h90, 1, 1'b1, 1'b1);
    `CHK("reload", 1, n_wr)
    `CHK("cb fail", 1'b1, fail_o)
    fin("copyback");
    // Pin-only wait, then an oversize page
    dev_fail <= 1'b0;
    run(OP_PROG, 'hA0, 1, 1'b1, 1'b0);
    `CHK("pin ready", 1'b1, rb_n_i)
    `CHK("pin fail", 1'b0, fail_o)
    `CHK("chip idle", 1'b1, ce_n_o)
    run(OP_PROG, 'hA1, 2113, 1'b1, 1'b1);
    `CHK("refused", 1'b1, seq_err_o)
    `CHK("refused bytes", 0, n_wr)
    fin("errors");
    wrap_up();
  end
endmodule : npess_host_test
